// ### src/ddr_rx_defines.vh
// register map, field positions, reset values and counts for the ddr data receiver
`ifndef DDR_RX_DEFINES_VH
`define DDR_RX_DEFINES_VH

// register offsets
`define OFS_IRQ_EN_LOW       8'h03
`define OFS_IRQ_EN_HIGH      8'h04
`define OFS_WINDOW_STATUS    8'h0c
`define OFS_RX_CONTROL       8'h10
`define OFS_WINDOW_DELAY     8'h13
`define OFS_SAMPLE_DELAY     8'h14
`define OFS_DELAY_HIGH       8'h15
`define OFS_LOCK_STATUS      8'h21

// field positions
`define BIT_TRACK_EN         0
`define BIT_LOOP_ON          1
`define BIT_FLAG_RESET       7
`define BIT_LATE_STATUS      0
`define BIT_EARLY_STATUS     2
`define BIT_LOCKED           0
`define BIT_LOST             1
`define BIT_TRACKING         2
`define BIT_SEARCHING        3
`define BIT_MARGIN_OK        4
`define BIT_IRQ_LOCK         3
`define BIT_IRQ_LOST         3

// reset values
`define RST_WINDOW_DELAY     8'h72
`define RST_DELAY            10'h0a7
`define RST_CONTROL          8'h00
`define RST_IRQ_EN           8'h00

// delay range and tracking margin
`define DELAY_MAX            10'h14e
`define MARGIN_LOW           10'h050
`define MARGIN_HIGH          10'h0fe

// timing counts
`define LOCK_LIMIT_CYC       135000
`define STEP_BASE_CYC        7'h04

`endif

// ### src/sync2.v
// two-stage synchroniser for pin inputs, any width
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter W = 1
)(
   input  wire         clk_sys,
   input  wire         sys_rst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] meta;

   // first stage feeds only the second stage
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         meta <= {W{1'b0}};
         dout <= {W{1'b0}};
      end
      else
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

// ### src/ddr_capture.v
// ddr capture of both sample ports, elastic fifo and odd/even reassembly
`timescale 1ns/1ps
`default_nettype none
module ddr_capture #(
   parameter SW    = 14,
   parameter DEPTH = 4,
   parameter AW    = 2
)(
   input  wire          clk_sys,
   input  wire          sys_rst,
   input  wire          clk_level,
   input  wire [SW-1:0] even_in,
   input  wire [SW-1:0] odd_in,
   output reg  [SW-1:0] sample,
   output reg           sample_valid
);
   reg [2*SW-1:0] mem [0:DEPTH-1];
   reg [AW:0]     wr_ptr;
   reg [AW:0]     rd_ptr;
   reg            clk_q;
   reg            half;
   wire           edge_seen = clk_level ^ clk_q;
   wire           empty     = (wr_ptr == rd_ptr);
   wire           full      = (wr_ptr[AW] != rd_ptr[AW]) &&
                              (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

   // both clock edges load a word pair; full drops the pair rather than stall the link
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         clk_q  <= 1'b0;
         wr_ptr <= {(AW+1){1'b0}};
      end
      else
      begin
         clk_q <= clk_level;
         if (edge_seen && !full)
         begin
            mem[wr_ptr[AW-1:0]] <= {odd_in, even_in};  // [R4] [R6]
            wr_ptr              <= wr_ptr + 1'b1;
         end
      end
   end

   // even sample first, then odd, restoring the original order; codes pass as offset binary
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rd_ptr       <= {(AW+1){1'b0}};
         half         <= 1'b0;
         sample       <= {SW{1'b0}};
         sample_valid <= 1'b0;
      end
      else if (!empty)
      begin
         sample_valid <= 1'b1;
         half         <= ~half;
         if (!half)
            sample <= mem[rd_ptr[AW-1:0]][SW-1:0];  // [R23] [R3]
         else
         begin
            sample <= mem[rd_ptr[AW-1:0]][2*SW-1:SW];  // [R23]
            rd_ptr <= rd_ptr + 1'b1;                   // [R6]
         end
      end
      else
         sample_valid <= 1'b0;
   end
endmodule
`default_nettype wire

// ### src/ddr_data_receiver.v
// dual-port ddr data receiver: registers, delay-lock controller and data path
//
// Summary of operation
// R1 - host drives two 14-bit ports, both edges
// R2 - host makes quarter-rate clock as data line; the bench host model makes an eighth-rate one
// R3 - samples are taken as offset binary
// R4 - data sampled by ninety-degree shifted clock
// R5 - output clock from fixed quarter-rate divider phase
// R6 - elastic fifo moves data into own domain
// R7 - control register bits enable and track
// R8 - early status reads 0, late reads 1
// R9 - window width field in low nibble
// R10 - software writes window register 0x72 at init
// R11 - software disables, then writes 0x02, 0x03
// R12 - software waits, checks lock status 0x05
// R13 - software rechecks delay, repeats if outside band
// R14 - search above, then below, pick closer edge
// R15 - ten-bit delays 0 to 334, default 167
// R16 - controller overwrites programmed delays while enabled
// R17 - margin is distance to nearer range limit
// R18 - software enables only after other loop locks
// R19 - lock within bounded cycle count or abandon
// R20 - lock status reports locked, lost, tracking
// R21 - enable bits route lock events to interrupt
// R22 - loop-on restarts search; flag reset pulse
// R23 - odd and even streams reassembled in order
// R24 - lost-lock flag sticks until flag reset
`timescale 1ns/1ps
`default_nettype none
`include "ddr_rx_defines.vh"
module ddr_data_receiver #(
   parameter SW         = 14,
   parameter LOCK_LIMIT = `LOCK_LIMIT_CYC
)(
   input  wire          clk_sys,
   input  wire          sys_rst,
   input  wire          input_data_clock,
   input  wire [SW-1:0] even_sample_port,
   input  wire [SW-1:0] odd_sample_port,
   input  wire          early_sample_pin,
   input  wire          late_sample_pin,
   input  wire [7:0]    reg_addr,
   input  wire [7:0]    reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [7:0]    reg_rdata,
   output reg           output_data_clock,
   output reg  [9:0]    clock_path_delay,
   output reg  [9:0]    sample_path_delay,
   output reg  [SW-1:0] dac_sample,
   output reg           dac_sample_valid,
   output reg           irq_out
);
   // one-hot controller states
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_UP    = 4'b0010;
   localparam [3:0] ST_DOWN  = 4'b0100;
   localparam [3:0] ST_TRACK = 4'b1000;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and data path

   wire          dci_s;
   wire [SW-1:0] even_s;
   wire [SW-1:0] odd_s;
   wire [1:0]    phase_s;
   wire [SW-1:0] cap_sample;
   wire          cap_valid;

   sync2 #(.W(2*SW+1)) u_sync_data (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .din     ({input_data_clock, odd_sample_port, even_sample_port}),
      .dout    ({dci_s, odd_s, even_s})
   );

   sync2 #(.W(2)) u_sync_phase (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .din     ({early_sample_pin, late_sample_pin}),
      .dout    (phase_s)
   );

   ddr_capture #(.SW(SW), .DEPTH(4), .AW(2)) u_capture (
      .clk_sys      (clk_sys),
      .sys_rst      (sys_rst),
      .clk_level    (dci_s),
      .even_in      (even_s),
      .odd_in       (odd_s),
      .sample       (cap_sample),
      .sample_valid (cap_valid)
   );

   wire early_now = phase_s[1];
   wire late_now  = phase_s[0];

   // one more stage so every top output leaves a flip-flop of this module
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         dac_sample       <= {SW{1'b0}};
         dac_sample_valid <= 1'b0;
      end
      else
      begin
         dac_sample       <= cap_sample;  // [R3]
         dac_sample_valid <= cap_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // quarter-rate divider and output clock

   reg [1:0] quarter_rate_divider;

   // the output clock always comes from bit one, a fixed phase of the divider
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         quarter_rate_divider <= 2'h0;
         output_data_clock    <= 1'b0;
      end
      else
      begin
         quarter_rate_divider <= quarter_rate_divider + 2'h1;
         output_data_clock    <= quarter_rate_divider[1];  // [R5]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // software registers

   reg [7:0] irq_enable_low;
   reg [7:0] irq_enable_high;
   reg [7:0] receiver_control;
   reg [7:0] window_and_clock_delay;
   reg [9:0] prog_delay;
   reg       receiver_locked;
   reg       lost_flag;
   reg       lock_flag;
   reg [3:0] state;

   wire       receiver_loop_on    = receiver_control[`BIT_LOOP_ON];
   wire       run                 = receiver_loop_on & receiver_control[`BIT_TRACK_EN];
   wire       receiver_flag_reset = receiver_control[`BIT_FLAG_RESET];
   wire [3:0] sampling_window_width = window_and_clock_delay[3:0];
   wire       wr_delay_lo = reg_wr && (reg_addr == `OFS_SAMPLE_DELAY);
   wire       wr_delay_hi = reg_wr && (reg_addr == `OFS_DELAY_HIGH);
   wire       margin_ok   = (clock_path_delay >= `MARGIN_LOW) &&
                            (clock_path_delay <= `MARGIN_HIGH);

   // register writes; delay writes land in the programmed start value only
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         irq_enable_low         <= `RST_IRQ_EN;
         irq_enable_high        <= `RST_IRQ_EN;
         receiver_control       <= `RST_CONTROL;
         window_and_clock_delay <= `RST_WINDOW_DELAY;
         prog_delay             <= `RST_DELAY;  // [R15]
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `OFS_IRQ_EN_LOW:    irq_enable_low         <= reg_wdata;
            `OFS_IRQ_EN_HIGH:   irq_enable_high        <= reg_wdata;
            `OFS_RX_CONTROL:    receiver_control       <= reg_wdata;  // [R7]
            `OFS_WINDOW_DELAY:  window_and_clock_delay <= reg_wdata;  // [R9]
            `OFS_SAMPLE_DELAY:  prog_delay[7:0]        <= reg_wdata;
            `OFS_DELAY_HIGH:    prog_delay[9:8]        <= reg_wdata[1:0];
            default:            prog_delay             <= prog_delay;
         endcase
      end
   end

   // registered read data, one cycle after the read strobe; unmapped reads give zero
   always @(posedge clk_sys)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `OFS_IRQ_EN_LOW:    reg_rdata <= irq_enable_low;
            `OFS_IRQ_EN_HIGH:   reg_rdata <= irq_enable_high;
            `OFS_WINDOW_STATUS: reg_rdata <= {5'h00, early_now, 1'b0, late_now};  // [R8]
            `OFS_RX_CONTROL:    reg_rdata <= receiver_control;
            `OFS_WINDOW_DELAY:  reg_rdata <= window_and_clock_delay;
            `OFS_SAMPLE_DELAY:  reg_rdata <= clock_path_delay[7:0];  // [R13]
            `OFS_DELAY_HIGH:    reg_rdata <= {6'h00, clock_path_delay[9:8]};
            `OFS_LOCK_STATUS:   reg_rdata <= {3'h0, margin_ok, state[1] | state[2],
                                              state[3], lost_flag, receiver_locked};  // [R20] [R17]
            default:            reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // delay-lock controller

   reg        run_q;
   reg [6:0]  step_cnt;
   reg [9:0]  start_pos;
   reg [9:0]  up_pos;
   reg        up_found;
   reg [17:0] lock_timer;

   // wider windows step faster; a narrow window waits longer between moves
   wire [6:0] step_len   = {1'b0, ~sampling_window_width, 2'b00} + `STEP_BASE_CYC;  // [R9]
   wire       step_due   = (step_cnt == 7'h00);
   wire       edge_found = late_now & ~early_now;  // [R8]
   wire       start      = run & ~run_q;           // [R22]
   wire       timed_out  = (lock_timer == LOCK_LIMIT[17:0]);
   wire [9:0] up_dist    = up_pos - start_pos;
   wire [9:0] dn_dist    = start_pos - clock_path_delay;

   // search up, search down, choose the closer edge, then hold it between early and late
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state             <= ST_IDLE;
         run_q             <= 1'b0;
         step_cnt          <= 7'h00;
         start_pos         <= `RST_DELAY;
         up_pos            <= `RST_DELAY;
         up_found          <= 1'b0;
         lock_timer        <= 18'h00000;
         receiver_locked   <= 1'b0;
         clock_path_delay  <= `RST_DELAY;
         sample_path_delay <= `RST_DELAY;
      end
      else
      begin
         run_q    <= run;
         step_cnt <= step_due ? step_len : step_cnt - 7'h01;
         if (state != ST_TRACK && state != ST_IDLE)
            lock_timer <= lock_timer + 18'h00001;
         case (state)
            ST_IDLE:
            begin
               receiver_locked <= 1'b0;
               if (!run)
               begin
                  clock_path_delay  <= prog_delay;
                  sample_path_delay <= prog_delay;
               end
               if (start)
               begin
                  state      <= ST_UP;  // [R14]
                  start_pos  <= prog_delay;
                  up_found   <= 1'b0;
                  lock_timer <= 18'h00000;
               end
            end
            ST_UP:
            begin
               if (!run || timed_out)
                  state <= ST_IDLE;  // [R19]
               else if (step_due)
               begin
                  if (edge_found || clock_path_delay == `DELAY_MAX)
                  begin
                     up_found          <= edge_found;
                     up_pos            <= clock_path_delay;
                     clock_path_delay  <= start_pos;  // [R14]
                     sample_path_delay <= start_pos;
                     state             <= ST_DOWN;
                  end
                  else
                  begin
                     clock_path_delay  <= clock_path_delay + 10'h001;  // [R16]
                     sample_path_delay <= clock_path_delay + 10'h001;
                  end
               end
            end
            ST_DOWN:
            begin
               if (!run || timed_out)
                  state <= ST_IDLE;  // [R19]
               else if (step_due)
               begin
                  if (edge_found && (!up_found || dn_dist <= up_dist))
                  begin
                     state           <= ST_TRACK;  // [R14]
                     receiver_locked <= 1'b1;
                  end
                  else if (edge_found || clock_path_delay == 10'h000)
                  begin
                     if (up_found)
                     begin
                        clock_path_delay  <= up_pos;  // [R14] [R16]
                        sample_path_delay <= up_pos;
                        state             <= ST_TRACK;
                        receiver_locked   <= 1'b1;
                     end
                     else
                        state <= ST_IDLE;
                  end
                  else
                  begin
                     clock_path_delay  <= clock_path_delay - 10'h001;
                     sample_path_delay <= clock_path_delay - 10'h001;  // [R4]
                  end
               end
            end
            ST_TRACK:
            begin
               if (!run)
                  state <= ST_IDLE;
               else if (step_due && early_now)
               begin
                  if (clock_path_delay == 10'h000)
                     state <= ST_IDLE;  // lost lock at range floor
                  else
                  begin
                     clock_path_delay  <= clock_path_delay - 10'h001;  // [R8] [R16]
                     sample_path_delay <= clock_path_delay - 10'h001;
                  end
               end
               else if (step_due && !late_now)
               begin
                  if (clock_path_delay == `DELAY_MAX)
                     state <= ST_IDLE;  // lost lock at range ceiling
                  else
                  begin
                     clock_path_delay  <= clock_path_delay + 10'h001;  // [R8] [R16]
                     sample_path_delay <= clock_path_delay + 10'h001;
                  end
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // sticky lock event flags and interrupt

   reg  locked_q;
   wire lock_rise = receiver_locked & ~locked_q;
   wire lock_fall = ~receiver_locked & locked_q & run;

   // flags clear while the flag reset bit is high; a new event in that cycle still sets
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         locked_q  <= 1'b0;
         lock_flag <= 1'b0;
         lost_flag <= 1'b0;
         irq_out   <= 1'b0;
      end
      else
      begin
         locked_q  <= receiver_locked;
         lock_flag <= lock_rise | (lock_flag & ~receiver_flag_reset);  // [R22]
         lost_flag <= lock_fall | (lost_flag & ~receiver_flag_reset);  // [R24]
         irq_out   <= (lock_flag & irq_enable_low[`BIT_IRQ_LOCK]) |
                      (lost_flag & irq_enable_high[`BIT_IRQ_LOST]);  // [R21]
      end
   end
endmodule
`default_nettype wire

// ### dv/ddr_rx_checker.sv
// port-level assertions and covers for the ddr data receiver
`timescale 1ns/1ps
`default_nettype none
`include "ddr_rx_defines.vh"
module ddr_rx_checker #(
   parameter SW         = 14,
   parameter LOCK_LIMIT = 135000
)(
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       output_data_clock,
   input wire logic [9:0] clock_path_delay,
   input wire logic [9:0] sample_path_delay,
   input wire logic       dac_sample_valid,
   input wire logic       irq_out
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   logic [2:0] cyc;
   logic       en_lock;
   logic       en_lost;
   ////////////////////////////////////////
   // edges since reset, so the divider check skips the start-up cycles
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cyc     <= 3'h0;
         en_lock <= 1'b0;
         en_lost <= 1'b0;
      end
      else
      begin
         if (cyc != 3'h7)
            cyc <= cyc + 3'h1;
         if (reg_wr && reg_addr == `OFS_IRQ_EN_LOW)
            en_lock <= reg_wdata[`BIT_IRQ_LOCK];
         if (reg_wr && reg_addr == `OFS_IRQ_EN_HIGH)
            en_lost <= reg_wdata[`BIT_IRQ_LOST];
      end
   end
   ////////////////////////////////////////
   AST_DELAYS_MATCH: assert property (sample_path_delay == clock_path_delay)
      else $error("sample delay differs from clock delay");
   AST_DELAY_RANGE: assert property (clock_path_delay <= `DELAY_MAX)
      else $error("delay code beyond its range");
   AST_RESET_STATE: assert property ($past(sys_rst) |-> clock_path_delay == `RST_DELAY
      && !irq_out && !dac_sample_valid && reg_rdata == 8'h00)
      else $error("wrong state after reset");
   AST_DCO_PERIOD: assert property (cyc >= 3'h4 |-> output_data_clock != $past(output_data_clock, 2))
      else $error("output clock is not a quarter of the system clock");
   AST_RDATA_HOLD: assert property (!$past(reg_rd) && !$past(sys_rst) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   AST_UNMAPPED_ZERO: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_IRQ_NEEDS_ENABLE: assert property ($rose(irq_out) |-> en_lock || en_lost)
      else $error("interrupt raised with both enables clear");
   AST_FLAG_RESET_CLEARS: assert property (reg_wr && reg_addr == `OFS_RX_CONTROL
      && reg_wdata[`BIT_FLAG_RESET] |-> ##[1:3] !irq_out)
      else $error("flag reset left the interrupt up");
   AST_PAIR_OUT: assert property ($rose(dac_sample_valid) |=> dac_sample_valid)
      else $error("even sample not followed by odd sample");
   COV_LOCK_IRQ: cover property ($rose(irq_out) && en_lock);
   COV_LOST_IRQ: cover property ($rose(irq_out) && en_lost);
   COV_STREAM: cover property (dac_sample_valid [*2]);
endmodule
bind ddr_data_receiver ddr_rx_checker #(.SW(SW), .LOCK_LIMIT(LOCK_LIMIT)) ddr_rx_checker_i (
   .clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .output_data_clock, .clock_path_delay, .sample_path_delay, .dac_sample_valid, .irq_out
);
`default_nettype wire

// ### dv/ddr_host_model.sv
// host model: ddr sample stream, eighth-rate clock line and phase detector
`timescale 1ns/1ps
`default_nettype none
module ddr_host_model (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [9:0]  clock_path_delay,
   input  wire logic [9:0]  edge_hi,
   input  wire logic [9:0]  edge_lo,
   output var  logic        input_data_clock,
   output var  logic [13:0] even_sample_port,
   output var  logic [13:0] odd_sample_port,
   output var  logic        early_sample_pin,
   output var  logic        late_sample_pin
);
   logic [1:0]  div;
   logic [13:0] val;
   logic [9:0]  edge_at;
   ////////////////////////////////////////
   // nearest clock edge in delay codes; all ones means no edge in range
   assign edge_at = ({1'b0, clock_path_delay} << 1) >= ({1'b0, edge_hi} + {1'b0, edge_lo})
                    ? edge_hi : edge_lo;
   initial {input_data_clock, even_sample_port, odd_sample_port, div, val} = '0;
   initial {early_sample_pin, late_sample_pin} = 2'b00;
   // clock line and data change together, one pair per toggle
   always @(posedge clk_sys)
   begin
      div <= sys_rst ? 2'h0 : div + 2'h1;
      if (!sys_rst && div == 2'h3)
      begin
         input_data_clock <= ~input_data_clock;
         even_sample_port <= val;
         odd_sample_port  <= val + 14'h0531;
         val              <= val + 14'h0a62;
      end
      // early once past the edge, late once at or past it
      early_sample_pin <= clock_path_delay > edge_at;
      late_sample_pin  <= clock_path_delay >= edge_at;
   end
endmodule
`default_nettype wire

// ### dv/ddr_data_receiver_tb.sv
// self-checking bench: registers, lock search, lost lock and sample stream
`timescale 1ns/1ps
`default_nettype none
module ddr_data_receiver_tb;
   localparam int LIM = 2000;
   logic        clk_sys, sys_rst, reg_wr, reg_rd, input_data_clock, irq_out;
   logic        early_sample_pin, late_sample_pin, output_data_clock, dac_sample_valid;
   logic [13:0] even_sample_port, odd_sample_port, dac_sample;
   logic [13:0] exp_smp = 14'h0000;
   logic [9:0]  clock_path_delay, sample_path_delay, edge_hi, edge_lo;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
   int          miscompares = 0, n_tests = 0, cycles = 0, k;
   logic [7:0]  ra [9] = '{8'h03, 8'h04, 8'h0c, 8'h10, 8'h13, 8'h14, 8'h15, 8'h21, 8'h40};
   logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h72, 8'ha7, 8'h00, 8'h10, 8'h00};
   ddr_data_receiver #(.SW(14), .LOCK_LIMIT(LIM)) ddr_data_receiver_i (
      .clk_sys, .sys_rst, .input_data_clock, .even_sample_port, .odd_sample_port,
      .early_sample_pin, .late_sample_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .output_data_clock, .clock_path_delay, .sample_path_delay,
      .dac_sample, .dac_sample_valid, .irq_out);
   ddr_host_model ddr_host_model_i (
      .clk_sys, .sys_rst, .clock_path_delay, .edge_hi, .edge_lo, .input_data_clock,
      .even_sample_port, .odd_sample_port, .early_sample_pin, .late_sample_pin);
   ////////////////////////////////////////
   task automatic report_and_stop;
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      cmp({8'h00, got}, {8'h00, exp});
   endtask
   task automatic chk_dly(input logic [9:0] got, input logic [9:0] exp);
      cmp({6'h00, got}, {6'h00, exp});
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      cmp({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic chk_smp(input logic [13:0] got, input logic [13:0] exp);
      cmp({2'b00, got}, {2'b00, exp});
   endtask
   // one write strobe, released a cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   // read strobe; data is registered, so it is taken one edge later
   task automatic rdr(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(posedge clk_sys);
      #1 rd = reg_rdata;
   endtask
   // polls lock status until the mask bits are all set, bounded by n reads
   task automatic wait_status(input logic [7:0] m, input int n);
      k = 0;
      do
      begin
         rdr(8'h21);
         k++;
      end while ((rd & m) != m && k < n);
   endtask
   // the outer delay loop is taken as already locked before this
   task automatic start_loop;
      wr(8'h10, 8'h00);
      wr(8'h10, 8'h02);
      wr(8'h10, 8'h03);
   endtask
   ////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         report_and_stop;
      end
   end
   // every output sample must be the next one of the host stream
   always @(negedge clk_sys)
      if (dac_sample_valid === 1'b1)
      begin
         chk_smp(dac_sample, exp_smp);
         exp_smp <= exp_smp + 14'h0531;
      end
   initial
   begin
      sys_rst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      edge_hi = 10'h0b1;
      edge_lo = 10'h096;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // writes to read-only and unmapped places must not stick
      foreach (ra[i])
         if (ra[i] inside {8'h0c, 8'h21, 8'h40})
            wr(ra[i], 8'hff);
      foreach (ra[i])
      begin
         rdr(ra[i]);
         chk_reg(rd, rv[i]);
      end
      wr(8'h13, 8'h72);
      wr(8'h13, 8'h7f);
      rdr(8'h13);
      chk_reg(rd, 8'h7f);
      // edge 177 above the start is closer than 150 below it
      start_loop;
      wait_status(8'h01, LIM);
      rdr(8'h21);
      chk_reg(rd, 8'h15);
      chk_dly(clock_path_delay, 10'h0b1);
      rdr(8'h14);
      chk_reg(rd, 8'hb1);
      rdr(8'h0c);
      chk_reg(rd, 8'h01);
      chk_bit(irq_out, 1'b0);
      // edge vanishes: tracking runs out of range and lock is lost
      wr(8'h04, 8'h08);
      edge_hi <= 10'h3ff;
      edge_lo <= 10'h3ff;
      wait_status(8'h02, 600);
      chk_bit(irq_out, 1'b1);
      edge_hi <= 10'h0b1;
      edge_lo <= 10'h096;
      repeat (300) @(posedge clk_sys);
      rdr(8'h21);
      chk_bit(rd[1], 1'b1);
      chk_bit(irq_out, 1'b1);
      wr(8'h10, 8'h83);
      wr(8'h10, 8'h03);
      rdr(8'h21);
      chk_bit(rd[1], 1'b0);
      chk_bit(irq_out, 1'b0);
      // restart from the programmed 167: edge 160 below beats 190 above
      wr(8'h04, 8'h00);
      wr(8'h10, 8'h80);
      wr(8'h14, 8'ha7);
      wr(8'h15, 8'h00);
      wr(8'h03, 8'h08);
      edge_hi <= 10'h0be;
      edge_lo <= 10'h0a0;
      start_loop;
      wait_status(8'h01, LIM);
      chk_dly(clock_path_delay, 10'h0a0);
      repeat (3) @(posedge clk_sys);
      chk_bit(irq_out, 1'b1);
      // no edge, narrow window: still searching at half the limit, idle after it
      wr(8'h10, 8'h80);
      wr(8'h13, 8'h72);
      edge_hi <= 10'h3ff;
      edge_lo <= 10'h3ff;
      start_loop;
      repeat (LIM / 2) @(posedge clk_sys);
      rdr(8'h21);
      chk_bit(rd[3], 1'b1);
      repeat (LIM / 2 + 400) @(posedge clk_sys);
      rdr(8'h21);
      chk_reg(rd & 8'h0b, 8'h00);
      chk_bit(exp_smp != 14'h0000, 1'b1);
      report_and_stop;
   end
endmodule
`default_nettype wire
